// [hdl/tpw_pkg.sv]
// Functional notes
// - idle counter holds twice dead time
// - count up to period, down to 2Td
// - compare set depends on count direction
// - even dead counters start on positive fall
// - odd dead counters start on negative fall
// - dead counters idle when dead time zero
// - dead counters read-only, no initialisation
// - buffers feed compare registers
// - buffered writes timed, free writes immediate
// - compare values derived from buffer, dead time
// - separate active level for each polarity
// - peak transfer next period, trough same
// - positive compare wave from upper/mid
// - negative compare wave from mid/lower
// - positive dead wave low while even counting
// - negative dead wave low while odd counting
// - outputs are compare AND opposite dead wave
// - outputs converted to selected pin level
// - clear pin fall reloads counter 2Td
// - toggle pin high while counting up
// - period and trough matches set flags
package tpw_pkg;
    localparam int TPW_W = 16;
    localparam logic [15:0] TPW_REG_INIT = 16'hFFFF;
    localparam logic [15:0] TPW_CNT_INIT = 16'h0000;
    localparam logic [15:0] TPW_ONE = 16'h0001;
    localparam logic [1:0] TPW_XFER_OFF = 2'h0;
    localparam logic [1:0] TPW_XFER_PEAK = 2'h1;
    localparam logic [1:0] TPW_XFER_TROUGH = 2'h2;
    localparam logic [1:0] TPW_XFER_BOTH = 2'h3;
    localparam int TPW_PHASES = 3;
endpackage

// [hdl/tpw_dead_counter.sv]
`timescale 1ns/100ps
`default_nettype none
module tpw_dead_counter
    import tpw_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // control
    input wire logic start,
    input wire logic [15:0] dead_time_value,
    // status
    output logic [15:0] dead_time_counter,
    output logic counting
);
    typedef struct packed {
        logic [15:0] cnt;
        logic run;
    } tpw_dc_s;
    tpw_dc_s st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        if (st_reg.run) begin
            if (st_reg.cnt == dead_time_value) begin
                st_next.cnt = TPW_CNT_INIT;
                st_next.run = 1'b0;
            end else begin
                st_next.cnt = st_reg.cnt + TPW_ONE;
            end
        end else if (start && dead_time_value != TPW_CNT_INIT) begin
            st_next.run = 1'b1;
            st_next.cnt = TPW_ONE;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_reg <= '{cnt: TPW_CNT_INIT, run: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign dead_time_counter = st_reg.cnt;
    assign counting = st_reg.run;
endmodule // tpw_dead_counter
`default_nettype wire

// [hdl/tpw_phase.sv]
`timescale 1ns/100ps
`default_nettype none
module tpw_phase
    import tpw_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // carrier state
    input wire logic [15:0] carrier_counter,
    input wire logic up,
    input wire logic running,
    input wire logic [15:0] dead_time_value,
    // compare registers
    input wire logic [15:0] upper_compare,
    input wire logic [15:0] mid_compare,
    input wire logic [15:0] lower_compare,
    // outputs
    output logic pos_output_wave,
    output logic neg_output_wave,
    output logic [15:0] pos_dead_count,
    output logic [15:0] neg_dead_count
);
    typedef struct packed {
        logic pos_cmp;
        logic neg_cmp;
    } tpw_ph_s;
    tpw_ph_s st_reg, st_next;
    logic pos_cnt_run, neg_cnt_run, pos_fall, neg_fall;

    always_comb begin
        st_next = st_reg;
        if (up) begin
            st_next.pos_cmp = carrier_counter >= upper_compare;
            st_next.neg_cmp = mid_compare > carrier_counter;
        end else begin
            st_next.pos_cmp = carrier_counter >= mid_compare;
            st_next.neg_cmp = lower_compare > carrier_counter;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_reg <= '{pos_cmp: 1'b0, neg_cmp: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign pos_fall = running && !up && st_reg.pos_cmp && !st_next.pos_cmp;
    assign neg_fall = running && up && st_reg.neg_cmp && !st_next.neg_cmp;

    tpw_dead_counter u_pos_dead (
        .clock(clock),
        .sys_rst(sys_rst),
        .start(pos_fall),
        .dead_time_value(dead_time_value),
        .dead_time_counter(pos_dead_count),
        .counting(pos_cnt_run)
    );
    tpw_dead_counter u_neg_dead (
        .clock(clock),
        .sys_rst(sys_rst),
        .start(neg_fall),
        .dead_time_value(dead_time_value),
        .dead_time_counter(neg_dead_count),
        .counting(neg_cnt_run)
    );

    // dead waves are 1 unless their counter runs
    assign pos_output_wave = st_reg.pos_cmp & !neg_cnt_run;
    assign neg_output_wave = st_reg.neg_cmp & !pos_cnt_run;
endmodule // tpw_phase
`default_nettype wire

// [hdl/tpw_pwm.sv]
`timescale 1ns/100ps
`default_nettype none
module tpw_pwm
    import tpw_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // mode and control
    input wire logic count_run_bit,
    input wire logic transfer_timing_hi,
    input wire logic transfer_timing_lo,
    input wire logic positive_level_select,
    input wire logic negative_level_select,
    input wire logic clear_toggle_is_output,
    // register write port
    input wire logic [15:0] dead_time_value,
    input wire logic [15:0] wr_data,
    input wire logic period_buffer_wr,
    input wire logic [2:0] phase_buffer_wr,
    input wire logic [2:0] phase_free_wr,
    input wire logic period_compare_wr,
    // clear/toggle pin
    input wire logic clear_toggle_pin_in,
    output logic clear_toggle_pin_out,
    output logic clear_toggle_pin_oe_n,
    // status readback
    output logic [15:0] carrier_counter,
    output logic [15:0] period_buffer,
    output logic [15:0] period_compare,
    output logic [47:0] phase_buffers,
    output logic [47:0] upper_compares,
    output logic [47:0] mid_compares,
    output logic [47:0] lower_compares,
    output logic [95:0] dead_time_counters,
    output logic count_up,
    output logic peak_match_flag,
    output logic trough_match_flag,
    input wire logic peak_flag_clr,
    input wire logic trough_flag_clr,
    // pwm pins
    output logic u_positive_out,
    output logic u_negative_out,
    output logic v_positive_out,
    output logic v_negative_out,
    output logic w_positive_out,
    output logic w_negative_out
);
    typedef struct packed {
        logic [15:0] cnt;
        logic up;
        logic [15:0] pbuf;
        logic [15:0] pcmp;
        logic [2:0][15:0] buf_v;
        logic [2:0][15:0] upc;
        logic [2:0][15:0] midc;
        logic [2:0][15:0] lowc;
        logic clr_d;
        logic fpeak;
        logic ftrough;
        logic [5:0] pins;
    } tpw_top_s;
    tpw_top_s st_reg, st_next;

    logic [15:0] twice_td;
    logic [1:0] xfer_sel;
    logic at_peak, at_trough, do_xfer, clr_fall;
    logic [2:0] pos_wave, neg_wave;

    assign twice_td = 16'(dead_time_value + dead_time_value);
    assign xfer_sel = {transfer_timing_hi, transfer_timing_lo};

    function automatic logic [15:0] add16(input logic [15:0] a,
                                          input logic [15:0] b);
        return 16'(a + b);
    endfunction

    always_comb begin
        st_next = st_reg;
        at_peak = count_run_bit && st_reg.up
            && st_reg.cnt == st_reg.pcmp;
        at_trough = count_run_bit && !st_reg.up
            && st_reg.cnt == twice_td;
        do_xfer = (at_peak && (xfer_sel == TPW_XFER_PEAK
                || xfer_sel == TPW_XFER_BOTH))
            || (at_trough && (xfer_sel == TPW_XFER_TROUGH
                || xfer_sel == TPW_XFER_BOTH));
        clr_fall = !clear_toggle_is_output && st_reg.clr_d
            && !clear_toggle_pin_in;
        st_next.clr_d = clear_toggle_pin_in;
        // carrier counter
        if (!count_run_bit) begin
            st_next.cnt = twice_td;
            st_next.up = 1'b1;
        end else if (clr_fall) begin
            st_next.cnt = twice_td;
            st_next.up = 1'b1;
        end else if (at_peak) begin
            st_next.cnt = st_reg.cnt - TPW_ONE;
            st_next.up = 1'b0;
        end else if (at_trough) begin
            st_next.cnt = st_reg.cnt + TPW_ONE;
            st_next.up = 1'b1;
        end else if (st_reg.up) begin
            st_next.cnt = st_reg.cnt + TPW_ONE;
        end else begin
            st_next.cnt = st_reg.cnt - TPW_ONE;
        end
        // buffer writes
        if (period_buffer_wr) begin
            st_next.pbuf = wr_data;
        end
        if (period_compare_wr) begin
            st_next.pcmp = wr_data;
        end
        for (int i = 0; i < TPW_PHASES; i++) begin
            if (phase_buffer_wr[i] || phase_free_wr[i]) begin
                st_next.buf_v[i] = wr_data;
            end
        end
        // timed transfer uses the value being written, if any
        if (do_xfer) begin
            st_next.pcmp = add16(st_next.pbuf, twice_td);
        end
        for (int i = 0; i < TPW_PHASES; i++) begin
            if (do_xfer || phase_free_wr[i]) begin
                st_next.midc[i] = add16(st_next.buf_v[i],
                                        dead_time_value);
                st_next.upc[i] = add16(st_next.buf_v[i], twice_td);
                st_next.lowc[i] = st_next.buf_v[i];
            end
        end
        // status flags: set wins over clear
        if (peak_flag_clr) begin
            st_next.fpeak = 1'b0;
        end
        if (trough_flag_clr) begin
            st_next.ftrough = 1'b0;
        end
        if (at_peak) begin
            st_next.fpeak = 1'b1;
        end
        if (at_trough) begin
            st_next.ftrough = 1'b1;
        end
        for (int i = 0; i < TPW_PHASES; i++) begin
            st_next.pins[2 * i] = pos_wave[i] ~^ positive_level_select;
            st_next.pins[2 * i + 1] = neg_wave[i] ~^ negative_level_select;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_reg.cnt <= TPW_CNT_INIT;
            st_reg.up <= 1'b1;
            st_reg.pbuf <= TPW_REG_INIT;
            st_reg.pcmp <= TPW_REG_INIT;
            st_reg.buf_v <= {TPW_PHASES{TPW_REG_INIT}};
            st_reg.upc <= {TPW_PHASES{TPW_REG_INIT}};
            st_reg.midc <= {TPW_PHASES{TPW_REG_INIT}};
            st_reg.lowc <= {TPW_PHASES{TPW_REG_INIT}};
            st_reg.clr_d <= 1'b1;
            st_reg.fpeak <= 1'b0;
            st_reg.ftrough <= 1'b0;
            st_reg.pins <= 6'h00;
        end else begin
            st_reg <= st_next;
        end
    end

    for (genvar g = 0; g < TPW_PHASES; g++) begin : g_phase
        tpw_phase u_phase (
            .clock(clock),
            .sys_rst(sys_rst),
            .carrier_counter(st_reg.cnt),
            .up(st_reg.up),
            .running(count_run_bit),
            .dead_time_value(dead_time_value),
            .upper_compare(st_reg.upc[g]),
            .mid_compare(st_reg.midc[g]),
            .lower_compare(st_reg.lowc[g]),
            .pos_output_wave(pos_wave[g]),
            .neg_output_wave(neg_wave[g]),
            .pos_dead_count(dead_time_counters[32 * g +: 16]),
            .neg_dead_count(dead_time_counters[32 * g + 16 +: 16])
        );
    end

    assign carrier_counter = st_reg.cnt;
    assign count_up = st_reg.up;
    assign period_buffer = st_reg.pbuf;
    assign period_compare = st_reg.pcmp;
    assign phase_buffers = st_reg.buf_v;
    assign upper_compares = st_reg.upc;
    assign mid_compares = st_reg.midc;
    assign lower_compares = st_reg.lowc;
    assign peak_match_flag = st_reg.fpeak;
    assign trough_match_flag = st_reg.ftrough;
    assign clear_toggle_pin_out = st_reg.up;
    assign clear_toggle_pin_oe_n = !clear_toggle_is_output;
    assign u_positive_out = st_reg.pins[0];
    assign u_negative_out = st_reg.pins[1];
    assign v_positive_out = st_reg.pins[2];
    assign v_negative_out = st_reg.pins[3];
    assign w_positive_out = st_reg.pins[4];
    assign w_negative_out = st_reg.pins[5];
endmodule // tpw_pwm
`default_nettype wire

// [tb/tpw_pwm_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module tpw_pwm_monitor (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // control
    input wire logic count_run_bit,
    input wire logic transfer_timing_hi,
    input wire logic transfer_timing_lo,
    input wire logic clear_toggle_is_output,
    input wire logic clear_toggle_pin_in,
    input wire logic [15:0] dead_time_value,
    input wire logic [15:0] wr_data,
    input wire logic period_buffer_wr,
    input wire logic [2:0] phase_free_wr,
    input wire logic period_compare_wr,
    // status
    input wire logic [15:0] carrier_counter,
    input wire logic [15:0] period_buffer,
    input wire logic [15:0] period_compare,
    input wire logic [47:0] upper_compares,
    input wire logic [47:0] mid_compares,
    input wire logic [47:0] lower_compares,
    input wire logic [95:0] dead_time_counters,
    input wire logic count_up,
    input wire logic peak_match_flag,
    input wire logic trough_match_flag,
    input wire logic clear_toggle_pin_out
);
    logic [15:0] td2;
    logic pin_q, clr_fall, run_up, run_dn, xfer, dc_ok;
    assign td2 = {dead_time_value[14:0], 1'b0};
    assign clr_fall = !clear_toggle_is_output && pin_q
        && !clear_toggle_pin_in;
    assign run_up = count_run_bit && !clr_fall && count_up;
    assign run_dn = count_run_bit && !clr_fall && !count_up;
    assign xfer = (run_up && transfer_timing_lo
        && carrier_counter == period_compare)
        || (run_dn && transfer_timing_hi && carrier_counter == td2);
    always_ff @(posedge clock) begin
        pin_q <= sys_rst || clear_toggle_pin_in;
    end
    always_comb begin
        dc_ok = 1'b1;
        for (int i = 0; i < 6; i++) begin
            if (dead_time_counters[16*i +: 16] > dead_time_value) begin
                dc_ok = 1'b0;
            end
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    AST_IDLE_LOAD:
        assert property (!count_run_bit |=> carrier_counter == $past(td2))
        else $error("idle counter wrong");
    AST_UP_STEP:
        assert property (run_up && carrier_counter != period_compare
            |=> carrier_counter == $past(carrier_counter) + 16'h0001)
        else $error("up count wrong");
    AST_DOWN_STEP:
        assert property (run_dn && carrier_counter != td2
            |=> carrier_counter == $past(carrier_counter) - 16'h0001)
        else $error("down count wrong");
    AST_PEAK_TURN:
        assert property (run_up && carrier_counter == period_compare
            |=> !count_up && peak_match_flag)
        else $error("no turn at peak");
    AST_TROUGH_TURN:
        assert property (run_dn && carrier_counter == td2
            |=> count_up && trough_match_flag)
        else $error("no turn at trough");
    AST_EXT_CLEAR:
        assert property (count_run_bit && clr_fall
            |=> carrier_counter == $past(td2))
        else $error("external clear missed");
    AST_TOGGLE_DIR:
        assert property (clear_toggle_is_output && count_run_bit
            |=> clear_toggle_pin_out
                == (carrier_counter == $past(carrier_counter) + 16'h0001))
        else $error("toggle pin wrong");
    AST_FREE_LOAD:
        assert property (phase_free_wr[0] && !xfer |=>
            mid_compares[15:0] == $past(wr_data) + dead_time_value
            && upper_compares[15:0] == $past(wr_data) + td2
            && lower_compares[15:0] == $past(wr_data))
        else $error("free write load wrong");
    AST_PERIOD_XFER:
        assert property (xfer && !period_buffer_wr && !period_compare_wr
            |=> period_compare == $past(period_buffer) + td2)
        else $error("period transfer wrong");
    AST_NO_XFER:
        assert property (!transfer_timing_hi && !transfer_timing_lo
            && !period_compare_wr |=> $stable(period_compare))
        else $error("untimed transfer");
    AST_DEAD_BOUND:
        assert property (dc_ok)
        else $error("dead counter past limit");
    cover property (run_up && carrier_counter == period_compare);
    cover property (count_run_bit && clr_fall);
    cover property (xfer);
endmodule // tpw_pwm_monitor
bind tpw_pwm tpw_pwm_monitor u_tpw_pwm_monitor (.*);
`default_nettype wire

// [tb/tpw_power_stage.sv]
`timescale 1ns/100ps
`default_nettype none
module tpw_power_stage (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // gates {w_n, w_p, v_n, v_p, u_n, u_p}
    input wire logic [5:0] gate,
    input wire logic positive_level_select,
    input wire logic negative_level_select,
    // health
    output logic shoot_through,
    output logic [15:0] high_side_pulses
);
    logic [5:0] pol, on_q;
    wire logic [5:0] on = ~(gate ^ pol);
    // levels lag a cycle, like the registered pins
    always_ff @(posedge clock) begin
        pol <= {3{negative_level_select, positive_level_select}};
        on_q <= on;
        if (sys_rst) begin
            shoot_through <= 1'b0;
            high_side_pulses <= 16'h0000;
        end else begin
            if (|(on & (on >> 1) & 6'h15)) begin
                shoot_through <= 1'b1;
            end
            if (on[0] && !on_q[0]) begin
                high_side_pulses <= high_side_pulses + 16'h0001;
            end
        end
    end
endmodule // tpw_power_stage
`default_nettype wire

// [tb/tpw_pwm_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module tpw_pwm_bench;
    import tpw_pkg::*;
    logic clock = 1'b0, sys_rst = 1'b1, run = 1'b0, t_hi = 1'b0;
    logic t_lo = 1'b0, pls = 1'b1, nls = 1'b1, tog = 1'b1, clr_drv = 1'b1;
    logic pb_wr = 1'b0, pc_wr = 1'b0, pk_clr = 1'b0, tr_clr = 1'b0;
    logic [2:0] buf_wr = 3'h0, free_wr = 3'h0;
    logic [15:0] td = 16'h0004, wd = 16'h0000;
    logic [15:0] cnt, pbuf, pcmp, pulses;
    logic [47:0] bufs, upc, midc, lowc;
    logic [95:0] dcs;
    logic [5:0] pins;
    logic up, pk, tr, ct_out, ct_oe_n, st, clr_in;
    int n_errors = 0;
    int checked = 0;
    assign clr_in = ct_oe_n ? clr_drv : ct_out;
    always #4 clock = ~clock;
    tpw_pwm u_tpw_pwm (
        .clock(clock), .sys_rst(sys_rst), .count_run_bit(run),
        .transfer_timing_hi(t_hi), .transfer_timing_lo(t_lo),
        .positive_level_select(pls), .negative_level_select(nls),
        .clear_toggle_is_output(tog), .dead_time_value(td), .wr_data(wd),
        .period_buffer_wr(pb_wr), .phase_buffer_wr(buf_wr),
        .phase_free_wr(free_wr), .period_compare_wr(pc_wr),
        .clear_toggle_pin_in(clr_in), .clear_toggle_pin_out(ct_out),
        .clear_toggle_pin_oe_n(ct_oe_n), .carrier_counter(cnt),
        .period_buffer(pbuf), .period_compare(pcmp), .phase_buffers(bufs),
        .upper_compares(upc), .mid_compares(midc), .lower_compares(lowc),
        .dead_time_counters(dcs), .count_up(up), .peak_match_flag(pk),
        .trough_match_flag(tr), .peak_flag_clr(pk_clr),
        .trough_flag_clr(tr_clr), .u_positive_out(pins[0]),
        .u_negative_out(pins[1]), .v_positive_out(pins[2]),
        .v_negative_out(pins[3]), .w_positive_out(pins[4]),
        .w_negative_out(pins[5]));
    tpw_power_stage u_tpw_power_stage (.clock(clock), .sys_rst(sys_rst),
        .gate(pins), .positive_level_select(pls),
        .negative_level_select(nls), .shoot_through(st),
        .high_side_pulses(pulses));
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // strobes {period, buffered w v u, free w v u, period compare}
    task automatic wr(input logic [15:0] v, input logic [7:0] s);
        @(posedge clock);
        wd <= v;
        {pb_wr, buf_wr, free_wr, pc_wr} <= s;
        @(posedge clock);
        {pb_wr, buf_wr, free_wr, pc_wr} <= 8'h00;
        #1;
    endtask
    task automatic wait_for(input logic peak);
        int i;
        @(posedge clock);
        {pk_clr, tr_clr} <= 2'h3;
        @(posedge clock);
        {pk_clr, tr_clr} <= 2'h0;
        i = 0;
        do begin
            cyc(1);
            i++;
        end while ((peak ? pk : tr) !== 1'b1 && i < 300);
        chk(i < 300, 1'b1);
    endtask
    task automatic t_setup;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        #1;
        chk({cnt, up, pk, tr, ct_out, pins}, {16'h0000, 4'h9, 6'h00});
        chk(dcs, 96'h0);
        chk({pbuf, pcmp, upc}, {80{1'b1}});
        cyc(2);
        chk(cnt, 16'h0008);
        wr(16'h0014, 8'h80);
        wr(16'h001C, 8'h01);
        for (int i = 0; i < 3; i++) begin
            wr(16'h0006 + 16'(4 * i), 8'h02 << i);
        end
        chk(midc, {16'h0012, 16'h000E, 16'h000A});
        chk(upc, {16'h0016, 16'h0012, 16'h000E});
        chk(lowc, {16'h000E, 16'h000A, 16'h0006});
        $display("test setup done");
    endtask
    task automatic t_run;
        logic [95:0] mx;
        mx = '0;
        wr(16'h001E, 8'h80);
        wr(16'h0008, 8'h10);
        chk({pbuf, bufs[15:0], upc[15:0]}, 48'h001E_0008_000E);
        @(posedge clock);
        {t_hi, t_lo} <= TPW_XFER_OFF;
        run <= 1'b1;
        wait_for(1'b1);
        chk({up, ct_out, ct_oe_n}, 3'h0);
        for (int i = 0; i < 80; i++) begin
            cyc(1);
            for (int j = 0; j < 6; j++) begin
                if (dcs[16*j +: 16] > mx[16*j +: 16]) begin
                    mx[16*j +: 16] = dcs[16*j +: 16];
                end
            end
        end
        chk(mx, {6{16'h0004}});
        chk({pcmp, st, pulses != 16'h0000}, 18'h00071);
        for (int k = 1; k < 4; k++) begin
            @(posedge clock);
            {t_hi, t_lo} <= k[1:0];
            wr(16'h0010 + 16'(k), 8'h80);
            wait_for(k != 2);
            chk(pcmp, 16'h0018 + 16'(k));
        end
        chk(upc[15:0], 16'h0010);
        $display("test run done");
    endtask
    task automatic t_clear;
        @(posedge clock);
        tog <= 1'b0;
        wait_for(1'b1);
        @(posedge clock);
        clr_drv <= 1'b0;
        @(posedge clock);
        clr_drv <= 1'b1;
        #1;
        chk({ct_oe_n, cnt == 16'h0008 || cnt == 16'h0009}, 2'h3);
        $display("test clear done");
    endtask
    task automatic t_levels;
        logic [5:0] p0;
        logic [95:0] acc;
        acc = '0;
        @(posedge clock);
        run <= 1'b0;
        cyc(12);
        p0 = pins;
        @(posedge clock);
        pls <= 1'b0;
        cyc(2);
        chk(pins, p0 ^ 6'h15);
        @(posedge clock);
        nls <= 1'b0;
        td <= 16'h0000;
        cyc(2);
        chk(pins, p0 ^ 6'h3F);
        @(posedge clock);
        run <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            cyc(1);
            acc |= dcs;
        end
        chk(acc, 96'h0);
        chk(st, 1'b0);
        $display("test levels done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        t_setup();
        t_run();
        t_clear();
        t_levels();
        final_report();
    end
    // more than ten times the expected run length
    initial begin
        #40000;
        n_errors++;
        final_report();
    end
endmodule // tpw_pwm_bench
`default_nettype wire
